// ===== pkg/serial_port_pkg.sv
package serial_port_pkg;
	// Register word addresses on the plain port
	localparam logic [15:0] ADDR_MODE = 16'hFFA8;
	localparam logic [15:0] ADDR_DATA = 16'hFFA9;
	localparam logic [15:0] ADDR_STATUS = 16'hFFB0;
	localparam logic [15:0] ADDR_MASK = 16'hFFB1;
	// Mode register fields
	localparam int ENABLE_BIT = 7;
	localparam int RX_ONLY_BIT = 2;
	localparam int CLK_SEL_HI = 1;
	localparam int CLK_SEL_LO = 0;
	localparam logic [7:0] MODE_WRITE_MASK = 8'h87;
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam int BITS_PER_FRAME = 8;
	// Internal clock divisions of the main clock
	localparam int DIV_SLOW = 128;
	localparam int DIV_FAST = 8;
	localparam int DIV_W = 7;
	localparam logic [1:0] SEL_EXT = 2'h0;
	localparam logic [1:0] SEL_TIMER = 2'h1;
	localparam logic [1:0] SEL_FAST = 2'h2;
	localparam logic [1:0] SEL_SLOW = 2'h3;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_LOW = 2'b01,
		ST_HIGH = 2'b10
	} shift_state_type;
endpackage : serial_port_pkg

// ===== pkg/sclk_if.sv
// Serial clock edge events shared between the clock generator and the shifter
interface sclk_if;
	logic fall;
	logic rise;
	logic run;
	modport gen (output fall, output rise, input run);
	modport use_edges (input fall, input rise, output run);
endinterface : sclk_if

// ===== design/sclk_gen.sv
// ****************************************
// Serial clock source selection
// ****************************************
module sclk_gen (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic [1:0] clk_sel,
	input wire logic ext_clk,
	input wire logic timer_output_source,
	sclk_if.gen edges
);
	import serial_port_pkg::*;
	logic [DIV_W-1:0] div_q, div_d;
	logic level_q, level_d;
	logic src;
	always_comb begin
		div_d = edges.run ? div_q + 7'h01 : 7'h00;
		if (clk_sel == SEL_EXT) begin
			src = ext_clk;
		end else if (clk_sel == SEL_TIMER) begin
			src = timer_output_source;
		end else if (clk_sel == SEL_FAST) begin
			// Half period is half the division; idle level high
			src = ~div_q[2];
		end else begin
			src = ~div_q[6];
		end
		level_d = edges.run ? src : 1'b1;
	end
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			div_q <= 7'h00;
			level_q <= 1'b1;
		end else begin
			div_q <= div_d;
			level_q <= level_d;
		end
	end
	assign edges.fall = edges.run & level_q & ~level_d;
	assign edges.rise = edges.run & ~level_q & level_d;
endmodule : sclk_gen

// ===== design/irq_ctrl.sv
// ****************************************
// Sticky status, mask and interrupt line
// ****************************************
module irq_ctrl (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic event_done,
	input wire logic status_wr,
	input wire logic mask_wr,
	input wire logic [7:0] wdata,
	output logic status,
	output logic mask,
	output logic irq
);
	logic status_d, mask_d, irq_d;
	always_comb begin
		// Set wins over a write-one clear
		status_d = event_done | (status & ~(status_wr & wdata[0]));
		mask_d = mask_wr ? wdata[0] : mask;
		irq_d = status_d & mask_d;
	end
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			status <= 1'b0;
			mask <= 1'b0;
			irq <= 1'b0;
		end else begin
			status <= status_d;
			mask <= mask_d;
			irq <= irq_d;
		end
	end
endmodule : irq_ctrl

// ===== design/three_wire_serial_port.sv
module three_wire_serial_port (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic [15:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [7:0] rdata,
	input wire logic serial_clock_in,
	output logic serial_clock_out,
	output logic serial_clock_oe,
	input wire logic serial_in_pin,
	output logic serial_out_pin,
	output logic serial_out_oe,
	input wire logic timer_output_source,
	output logic irq
);
	import serial_port_pkg::*;

	// ****************************************
	// Registers and state
	// ****************************************
	logic [7:0] mode_q, mode_d;
	logic [7:0] shift_q, shift_d;
	logic [3:0] count_q, count_d;
	logic out_latch_q, out_latch_d;
	logic in_bit_q, in_bit_d;
	shift_state_type state_q, state_d;
	logic [7:0] rdata_q, rdata_d;
	logic sclk_q, sclk_d, sclk_oe_q, sclk_oe_d, so_oe_q, so_oe_d;
	logic done;
	logic status, mask, irq_int;
	logic enable, rx_only, internal_clk, busy;
	logic start_tx, start_rx;
	sclk_if edges ();

	assign enable = mode_q[ENABLE_BIT];
	assign rx_only = mode_q[RX_ONLY_BIT];
	// Timer output is an on-chip source, so the clock pin is driven for it as well
	assign internal_clk = mode_q[CLK_SEL_HI:CLK_SEL_LO] != SEL_EXT;
	assign busy = state_q != ST_IDLE;
	assign edges.run = busy;

	sclk_gen u_sclk (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.clk_sel(mode_q[CLK_SEL_HI:CLK_SEL_LO]),
		.ext_clk(serial_clock_in),
		.timer_output_source(timer_output_source),
		.edges(edges)
	);

	irq_ctrl u_irq (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.event_done(done),
		.status_wr(wr_en && addr == ADDR_STATUS),
		.mask_wr(wr_en && addr == ADDR_MASK),
		.wdata(wdata),
		.status(status),
		.mask(mask),
		.irq(irq_int)
	);

	// ****************************************
	// Transfer control
	// ****************************************
	// Start only on an access made while enabled
	assign start_tx = enable && !rx_only && wr_en && addr == ADDR_DATA && !busy;
	assign start_rx = enable && rx_only && rd_en && addr == ADDR_DATA && !busy;

	always_comb begin
		mode_d = mode_q;
		shift_d = shift_q;
		count_d = count_q;
		state_d = state_q;
		out_latch_d = out_latch_q;
		// Input pin is registered in the same stage as the clock level
		in_bit_d = serial_in_pin;
		done = 1'b0;
		if (wr_en && addr == ADDR_MODE) begin
			mode_d = wdata & MODE_WRITE_MASK;
		end
		if (!enable) begin
			// Stop shifting and clear the counter
			state_d = ST_IDLE;
			count_d = 4'h0;
		end else if (start_tx) begin
			shift_d = wdata;
			out_latch_d = wdata[7];
			count_d = 4'h0;
			state_d = ST_HIGH;
		end else if (start_rx) begin
			count_d = 4'h0;
			state_d = ST_HIGH;
		end else if (busy) begin
			// Falling edge: next bit into the output latch, register moves up
			if (edges.fall && state_q == ST_HIGH) begin
				out_latch_d = shift_q[7];
				shift_d = {shift_q[6:0], 1'b0};
				state_d = ST_LOW;
			end
			// Rising edge: sampled bit lands in the freed low bit
			if (edges.rise && state_q == ST_LOW) begin
				shift_d = {shift_q[7:1], in_bit_q};
				count_d = count_q + 4'h1;
				state_d = ST_HIGH;
				// Eighth pulse ends the frame, clock stays high after it
				if (count_q == 4'(BITS_PER_FRAME - 1)) begin
					state_d = ST_IDLE;
					done = 1'b1;
				end
			end
		end
	end

	// ****************************************
	// Bus read and pin drive
	// ****************************************
	always_comb begin
		rdata_d = 8'h00;
		if (rd_en) begin
			if (addr == ADDR_MODE) begin
				rdata_d = mode_q;
			end else if (addr == ADDR_DATA) begin
				rdata_d = shift_q;
			end else if (addr == ADDR_STATUS) begin
				rdata_d = {busy, 6'h00, status};
			end else if (addr == ADDR_MASK) begin
				rdata_d = {7'h00, mask};
			end else begin
				rdata_d = 8'h00;
			end
		end
		sclk_oe_d = enable && internal_clk;
		sclk_d = busy ? (edges.fall ? 1'b0 : (edges.rise ? 1'b1 : sclk_q)) : 1'b1;
		so_oe_d = enable && !rx_only;
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			mode_q <= MODE_RESET;
			shift_q <= DATA_RESET;
			count_q <= 4'h0;
			state_q <= ST_IDLE;
			out_latch_q <= 1'b0;
			in_bit_q <= 1'b0;
			rdata_q <= 8'h00;
			sclk_q <= 1'b1;
			sclk_oe_q <= 1'b0;
			so_oe_q <= 1'b0;
		end else begin
			mode_q <= mode_d;
			shift_q <= shift_d;
			count_q <= count_d;
			state_q <= state_d;
			out_latch_q <= out_latch_d;
			in_bit_q <= in_bit_d;
			rdata_q <= rdata_d;
			sclk_q <= sclk_d;
			sclk_oe_q <= sclk_oe_d;
			so_oe_q <= so_oe_d;
		end
	end

	assign rdata = rdata_q;
	assign serial_clock_out = sclk_q;
	assign serial_clock_oe = sclk_oe_q;
	assign serial_out_pin = out_latch_q;
	assign serial_out_oe = so_oe_q;
	assign irq = irq_int;

	// ****************************************
	// Assertions
	// ****************************************
	a_disable_stops: assert property (@(posedge clk_sys) disable iff (!arst_n)
		!enable |=> !busy && count_q == 4'h0)
		else $error("transfer kept running while disabled");
	a_write_starts: assert property (@(posedge clk_sys) disable iff (!arst_n)
		start_tx |=> busy && shift_q == $past(wdata))
		else $error("write did not start transfer");
	a_read_starts: assert property (@(posedge clk_sys) disable iff (!arst_n)
		start_rx |=> busy)
		else $error("read did not start receive");
	a_rx_no_drive: assert property (@(posedge clk_sys) disable iff (!arst_n)
		rx_only |=> !serial_out_oe)
		else $error("output driven in receive-only mode");
	a_done_count: assert property (@(posedge clk_sys) disable iff (!arst_n)
		done |-> count_q == 4'h7 ##1 !busy && status)
		else $error("completion not after eight bits");
	a_no_start_off: assert property (@(posedge clk_sys) disable iff (!arst_n)
		!busy && !enable |=> !busy)
		else $error("transfer started while disabled");
	a_msb_out: assert property (@(posedge clk_sys) disable iff (!arst_n)
		start_tx |=> serial_out_pin == $past(wdata[7]))
		else $error("first bit is not the msb");
	a_reset_regs: assert property (@(posedge clk_sys)
		$rose(arst_n) |-> mode_q == 8'h00 && shift_q == 8'h00)
		else $error("registers not cleared by reset");
	a_rise_samples: assert property (@(posedge clk_sys) disable iff (!arst_n)
		busy && enable && edges.rise && state_q == ST_LOW |=> shift_q[0] == $past(in_bit_q))
		else $error("input bit not taken on rising edge");
	a_clk_drive: assert property (@(posedge clk_sys) disable iff (!arst_n)
		enable && internal_clk |=> serial_clock_oe)
		else $error("internal clock not driven on the pin");
	c_tx_done: cover property (@(posedge clk_sys) disable iff (!arst_n) !rx_only && done);
	c_rx_done: cover property (@(posedge clk_sys) disable iff (!arst_n) rx_only && done);
	c_irq: cover property (@(posedge clk_sys) disable iff (!arst_n) irq);
	c_timer_done: cover property (@(posedge clk_sys) disable iff (!arst_n)
		mode_q[CLK_SEL_HI:CLK_SEL_LO] == SEL_TIMER && done);
endmodule : three_wire_serial_port

// ===== tb/serial_peripheral_model.sv
// ****************************************
// Clocked serial peripheral on the far side
// ****************************************
module serial_peripheral_model (
	input wire logic sclk,
	input wire logic sdo,
	input wire logic load,
	input wire logic [7:0] tx_data,
	output logic sdi,
	output logic [7:0] rx_data,
	output int falls
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] sh;
	int rises;
	always @(posedge load) begin
		sh = tx_data;
		sdi = tx_data[7];
		falls = 0;
		rises = 0;
	end
	// Next bit leaves on each of the first eight falling edges after load, most significant first
	always @(negedge sclk) begin
		if (falls < 8) begin
			sdi <= sh[7];
			sh <= {sh[6:0], 1'b0};
		end
		falls <= falls + 1;
	end
	// Sample on rising edge; after the last bit the held level is gone
	always @(posedge sclk) begin
		rx_data <= {rx_data[6:0], sdo};
		rises <= rises + 1;
		if (rises == 7)
			sdi <= ~sdi;
	end
endmodule : serial_peripheral_model

// ===== tb/three_wire_serial_port_test.sv
module three_wire_serial_port_test;
	timeunit 1ns;
	timeprecision 1ns;
	import serial_port_pkg::*;
	logic clk_sys, arst_n, wr_en, rd_en, ext_clk, tmr, load;
	logic [15:0] addr;
	logic [7:0] wdata, rdata, rd_v, ptx, prx;
	logic sclk_o, sclk_oe, sin, sout, sout_oe, irq;
	wire sclk_line = sclk_oe ? sclk_o : ext_clk;
	int err_count, comparisons, falls;
	logic [7:0] modes [6] = '{8'h82, 8'h83, 8'h81, 8'h80, 8'h86, 8'h84};
	logic [7:0] txs [6] = '{8'hA5, 8'h5A, 8'h3C, 8'h81, 8'h00, 8'h00};
	logic [7:0] pins [6] = '{8'h3C, 8'hC3, 8'h96, 8'h7E, 8'hB4, 8'h4B};
	three_wire_serial_port dut_u (.clk_sys(clk_sys), .arst_n(arst_n), .addr(addr),
		.wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
		.serial_clock_in(ext_clk), .serial_clock_out(sclk_o), .serial_clock_oe(sclk_oe),
		.serial_in_pin(sin), .serial_out_pin(sout), .serial_out_oe(sout_oe),
		.timer_output_source(tmr), .irq(irq));
	serial_peripheral_model peer_u (.sclk(sclk_line), .sdo(sout), .load(load),
		.tx_data(ptx), .sdi(sin), .rx_data(prx), .falls(falls));
	// ****************************************
	// Clock, timer source and bus tasks
	// ****************************************
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	initial begin
		tmr = 1'b0;
		forever begin
			repeat (5) @(posedge clk_sys);
			tmr <= ~tmr;
		end
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic stop_test;
		$display("errors %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : stop_test
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clk_sys);
		wr_en <= 1'b0;
	endtask : wr
	task automatic rd(input logic [15:0] a);
		@(posedge clk_sys);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk_sys);
		rd_en <= 1'b0;
		#1 rd_v = rdata;
	endtask : rd
	task automatic wait_irq;
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 5000) begin
			@(posedge clk_sys);
			n++;
		end
		if (n >= 5000) begin
			err_count++;
			stop_test();
		end
	endtask : wait_irq
	// One frame in the given mode, peer answering with pin
	task automatic frame(input logic [7:0] mode, input logic [7:0] tx, input logic [7:0] pin);
		ptx = pin;
		load = 1'b1;
		#1 load = 1'b0;
		wr(ADDR_MODE, mode);
		if (mode[RX_ONLY_BIT])
			rd(ADDR_DATA);
		else
			wr(ADDR_DATA, tx);
		@(posedge clk_sys);
		#1 check({7'h00, sout_oe}, {7'h00, ~mode[RX_ONLY_BIT]});
		check({7'h00, sclk_oe}, {7'h00, mode[1:0] != SEL_EXT});
		if (mode[1:0] == SEL_EXT) begin
			repeat (8) begin
				repeat (6) @(posedge clk_sys);
				ext_clk <= 1'b0;
				repeat (6) @(posedge clk_sys);
				ext_clk <= 1'b1;
			end
		end
		wait_irq();
		check(8'(falls), 8'h08);
		// Drop enable first: a result read in receive-only mode would start a frame
		wr(ADDR_MODE, mode & 8'h7F);
		rd(ADDR_DATA);
		check(rd_v, pin);
		if (!mode[RX_ONLY_BIT])
			check(prx, tx);
		rd(ADDR_STATUS);
		check(rd_v, 8'h01);
		wr(ADDR_STATUS, 8'h01);
		@(posedge clk_sys);
		#1 check({7'h00, irq}, 8'h00);
	endtask : frame
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		arst_n = 1'b0;
		wr_en = 1'b0;
		rd_en = 1'b0;
		addr = 16'h0000;
		wdata = 8'h00;
		ext_clk = 1'b1;
		load = 1'b0;
		ptx = 8'h00;
		repeat (6) @(posedge clk_sys);
		arst_n <= 1'b1;
		rd(ADDR_MODE);
		check(rd_v, MODE_RESET);
		rd(ADDR_DATA);
		check(rd_v, DATA_RESET);
		rd(16'h0000);
		check(rd_v, 8'h00);
		wr(ADDR_MODE, 8'hFF);
		rd(ADDR_MODE);
		check(rd_v, MODE_WRITE_MASK);
		wr(ADDR_MODE, 8'h00);
		wr(ADDR_DATA, 8'hA5);
		wr(ADDR_MODE, 8'h82);
		repeat (4) @(posedge clk_sys);
		rd(ADDR_STATUS);
		check(rd_v, 8'h00);
		wr(ADDR_MASK, 8'h01);
		for (int i = 0; i < 6; i++)
			frame(modes[i], txs[i], pins[i]);
		wr(ADDR_MODE, 8'h82);
		wr(ADDR_DATA, 8'h99);
		repeat (20) @(posedge clk_sys);
		wr(ADDR_MODE, 8'h00);
		repeat (200) @(posedge clk_sys);
		#1 check({7'h00, sout_oe}, 8'h00);
		check({7'h00, sclk_oe}, 8'h00);
		rd(ADDR_STATUS);
		check(rd_v, 8'h00);
		stop_test();
	end
endmodule : three_wire_serial_port_test
